//--- rtl/vectored_interrupt_controller.sv
// How it works
// - any trigger sets its request flag, whatever the enables hold
// - a set flag is taken only while its own enable is 1
// - global enable at 0 blocks every source
// - on taking, push next-instruction address, then load the source vector
// - every source has its own vector address
// - taking an interrupt clears the global enable
// - triggers during service still set flags, which stay pending
// - nothing is taken while the stack is full
// - return-from-interrupt pops the saved address
// - a flag being set wakes the device from sleep or idle
// - over-voltage flag set when protection input exceeds reference
// - each comparator flag set when its output changes state
// - conversion flag set when a conversion finishes
// - memory write flag set when a write cycle ends
// - low-supply flag set when the detector reports low supply
// - servicing clears only the served source's flag
// - third control register: flags bits 7-4, enables 3-0, reset 0
// - fourth control register: flags bits 7-4, enables 3-0, reset 0
// - return-from-interrupt sets the global enable; plain return does not
// - wake follows a flag's rising edge, independent of all enables
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module vectored_interrupt_controller
    import irq_pkg::*;
#(
    parameter bit LOW_INDEX_FIRST = 1'b1
) (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          resetn_i,
    // register port
    input  wire logic [1:0]                    reg_addr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [7:0]                    reg_rdata_o,
    // processor core and stack
    input  wire logic [irq_pkg::PC_WIDTH-1:0]  pc_i,
    input  wire logic                          core_ready_i,
    input  wire logic                          stack_full_i,
    input  wire logic                          return_from_interrupt_i,
    input  wire logic                          ret_i,
    output irq_pkg::core_req_type              core_o,
    output logic                               wake_o,
    // peripheral event pulses, same clock
    input  wire logic [2:0]                    timer_ovf_i,
    input  wire logic                          conversion_done_i,
    input  wire logic                          mem_write_done_i,
    input  wire logic [3:0]                    pulse_events_i,
    input  wire logic                          serial_bus_event_i,
    // analog levels, asynchronous
    input  wire logic [irq_pkg::NUM_ANALOG-1:0] analog_level_i
);
    import irq_pkg::*;

    logic [NUM_SRC-1:0]    flags_reg;
    logic [NUM_SRC-1:0]    flags_next;
    logic [NUM_SRC-1:0]    enables_reg;
    logic [NUM_SRC-1:0]    enables_next;
    logic                  gie_reg;
    logic                  gie_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic                  wake_reg;
    core_req_type          core_reg;
    core_req_type          core_next;
    logic [NUM_ANALOG-1:0] meta_reg;
    logic [NUM_ANALOG-1:0] sync_reg;
    logic [NUM_ANALOG-1:0] prev_reg;

    // two-flop synchronisers; only sync_reg/prev_reg feed logic
    genvar g;
    generate
        for (g = 0; g < NUM_ANALOG; g++) begin : gen_sync
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                    prev_reg[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= analog_level_i[g];
                    sync_reg[g] <= meta_reg[g];
                    prev_reg[g] <= sync_reg[g];
                end
            end
        end
    endgenerate

    wire [NUM_ANALOG-1:0] ana_rise   = sync_reg & ~prev_reg;
    wire [NUM_ANALOG-1:0] ana_change = sync_reg ^ prev_reg;

    // trigger conditions per source
    logic [NUM_SRC-1:0] events;
    assign events[SRC_OVP]     = ana_rise[ANA_OVP];
    assign events[SRC_CMP1]    = ana_change[ANA_CMP1];
    assign events[SRC_CMP2]    = ana_change[ANA_CMP2];
    assign events[SRC_CMP3]    = ana_change[ANA_CMP3];
    assign events[SRC_LOW_SUP] = ana_rise[ANA_LOW_SUP];
    assign events[SRC_CONV]    = conversion_done_i;
    assign events[SRC_MEM_WR]  = mem_write_done_i;
    assign events[SRC_TIMER0]  = timer_ovf_i[0];
    assign events[SRC_TIMER1]  = timer_ovf_i[1];
    assign events[SRC_TIMER2]  = timer_ovf_i[2];
    assign events[SRC_PPG_INT] = pulse_events_i[0];
    assign events[SRC_P_TIMER] = pulse_events_i[1];
    assign events[SRC_P_CMP]   = pulse_events_i[2];
    assign events[SRC_P_RETRG] = pulse_events_i[3];
    assign events[SRC_SERIAL]  = serial_bus_event_i;

    // register decode
    wire wr_first  = reg_wr_i && (reg_addr_i == IRQ_CONTROL_FIRST_OFS);
    wire wr_second = reg_wr_i && (reg_addr_i == IRQ_CONTROL_SECOND_OFS);
    wire wr_third  = reg_wr_i && (reg_addr_i == IRQ_CONTROL_THIRD_OFS);
    wire wr_fourth = reg_wr_i && (reg_addr_i == IRQ_CONTROL_FOURTH_OFS);

    wire [NUM_SRC-1:0] sw_mask = {{4{wr_fourth}}, {4{wr_third}}, {4{wr_second}},
                                  {3{wr_first}}};
    wire [NUM_SRC-1:0] sw_flag = {reg_wdata_i[7:4], reg_wdata_i[7:4], reg_wdata_i[7:4],
                                  reg_wdata_i[6:4]};
    wire [NUM_SRC-1:0] sw_en   = {reg_wdata_i[3:0], reg_wdata_i[3:0], reg_wdata_i[3:0],
                                  reg_wdata_i[3:1]};

    wire [7:0] ctrl_first  = {1'b0, flags_reg[2:0], enables_reg[2:0], gie_reg};
    wire [7:0] ctrl_second = {flags_reg[6:3], enables_reg[6:3]};
    wire [7:0] ctrl_third  = {flags_reg[10:7], enables_reg[10:7]};
    wire [7:0] ctrl_fourth = {flags_reg[14:11], enables_reg[14:11]};

    // priority pick; order chosen at build time
    function automatic logic [SRC_IDX_W-1:0] pick(input logic [NUM_SRC-1:0] req);
        logic [SRC_IDX_W-1:0] w;
        w = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (LOW_INDEX_FIRST) begin
                if (req[NUM_SRC-1-i]) begin
                    w = SRC_IDX_W'(NUM_SRC-1-i);
                end
            end else begin
                if (req[i]) begin
                    w = SRC_IDX_W'(i);
                end
            end
        end
        return w;
    endfunction

    wire [NUM_SRC-1:0]   pending = flags_reg & enables_reg;
    wire [SRC_IDX_W-1:0] winner  = pick(pending);
    // stack full holds every request off until the core pops
    wire take = gie_reg && (|pending) && !stack_full_i && core_ready_i;
    wire [NUM_SRC-1:0]   take_onehot = take ? (NUM_SRC'(1) << winner) : '0;
    wire [PC_WIDTH-1:0]  vector_addr =
        PC_WIDTH'(VECTOR_BASE + VECTOR_STEP * int'(winner));

    // events win over both software clears and service clears
    assign flags_next = (((flags_reg & ~sw_mask) | (sw_flag & sw_mask))
                         & ~take_onehot)
                        | events;
    assign enables_next = (enables_reg & ~sw_mask) | (sw_en & sw_mask);

    // taking beats a same-cycle return or write so no second call slips in
    assign gie_next = take     ? 1'b0 :
                      return_from_interrupt_i   ? 1'b1 :
                      wr_first ? reg_wdata_i[GIE_BIT] : gie_reg;

    assign rdata_next = !reg_rd_i                               ? 8'h00 :
                        (reg_addr_i == IRQ_CONTROL_FIRST_OFS)  ? ctrl_first :
                        (reg_addr_i == IRQ_CONTROL_SECOND_OFS) ? ctrl_second :
                        (reg_addr_i == IRQ_CONTROL_THIRD_OFS)  ? ctrl_third : ctrl_fourth;

    assign core_next.call    = take;
    assign core_next.pop     = return_from_interrupt_i || ret_i;
    assign core_next.vector  = take ? vector_addr : core_reg.vector;
    assign core_next.push_pc = take ? pc_i : core_reg.push_pc;

    // wake on any rising flag, enables play no part
    wire wake_next = |(flags_next & ~flags_reg);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_reg   <= '0;
            enables_reg <= '0;
            gie_reg     <= 1'b0;
            rdata_reg   <= IRQ_CONTROL_RESET;
            wake_reg    <= 1'b0;
            core_reg    <= '0;
        end else begin
            flags_reg   <= flags_next;
            enables_reg <= enables_next;
            gie_reg     <= gie_next;
            rdata_reg   <= rdata_next;
            wake_reg    <= wake_next;
            core_reg    <= core_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign core_o      = core_reg;
    assign wake_o      = wake_reg;

    // assertion helpers: register views rebuilt from source numbers
    wire [7:0] third_view  = {flags_reg[SRC_MEM_WR], flags_reg[SRC_TIMER2],
                              flags_reg[SRC_TIMER1], flags_reg[SRC_LOW_SUP],
                              enables_reg[SRC_MEM_WR], enables_reg[SRC_TIMER2],
                              enables_reg[SRC_TIMER1], enables_reg[SRC_LOW_SUP]};
    wire [7:0] fourth_view = {flags_reg[SRC_SERIAL], flags_reg[SRC_P_RETRG],
                              flags_reg[SRC_P_CMP], flags_reg[SRC_P_TIMER],
                              enables_reg[SRC_SERIAL], enables_reg[SRC_P_RETRG],
                              enables_reg[SRC_P_CMP], enables_reg[SRC_P_TIMER]};
    // flags that must survive this edge unless software writes them
    wire [NUM_SRC-1:0] kept_flags   = flags_reg & ~take_onehot;
    // sources that would outrank the winner under the build-time order
    wire [NUM_SRC-1:0] below_winner = ~({NUM_SRC{1'b1}} << winner);
    wire [NUM_SRC-1:0] outrank_mask = LOW_INDEX_FIRST ? below_winner :
                                      (~below_winner & ~(NUM_SRC'(1) << winner));

    a_event_sets_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (events != '0) |=> ((flags_reg & $past(events)) == $past(events)))
        else $error("trigger did not set its flag");

    a_disabled_no_take: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ((flags_reg & enables_reg) == '0) |=> !core_reg.call)
        else $error("call taken with no enabled pending flag");

    a_global_off_block: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !gie_reg |=> !core_reg.call)
        else $error("call taken with global enable low");

    a_push_next_pc: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        core_reg.call |-> (core_reg.push_pc == $past(pc_i)))
        else $error("pushed address is not the sampled pc");

    a_vector_per_src: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        core_reg.call |->
            (core_reg.vector == PC_WIDTH'(VECTOR_BASE + VECTOR_STEP * int'($past(winner))))
            && $past(pending[winner]))
        else $error("vector does not match served source");

    a_take_clears_gie: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        core_reg.call |-> !gie_reg ##1 !core_reg.call)
        else $error("global enable not cleared by taking");

    a_full_stack_hold: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        stack_full_i |=> !core_reg.call)
        else $error("call taken while stack full");

    a_return_pops: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (return_from_interrupt_i && !take) |=> (core_reg.pop && gie_reg))
        else $error("return did not pop and re-enable");

    a_plain_ret_keeps: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ret_i && !return_from_interrupt_i && !gie_reg && !wr_first) |=> (core_reg.pop && !gie_reg))
        else $error("plain return changed global enable");

    a_flag_rise_wakes: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ((flags_reg & ~$past(flags_reg)) != '0) |-> wake_o)
        else $error("flag rose without wake");

    a_service_clears: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (take && ((events & take_onehot) == '0)) |=>
            ((flags_reg & $past(take_onehot)) == '0))
        else $error("served flag not cleared");

    a_others_untouched: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (take && !reg_wr_i && (events == '0)) |=>
            (flags_reg == $past(kept_flags)))
        else $error("service changed another flag");

    // without a write a flag only drops when its own source is served
    a_pending_kept: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !reg_wr_i |=> ((flags_reg & $past(kept_flags)) == $past(kept_flags)))
        else $error("pending flag lost");

    a_enabled_winner: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take |-> (flags_reg[winner] && enables_reg[winner]))
        else $error("served source not flagged and enabled");

    a_fixed_priority: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take |-> ((pending & outrank_mask) == '0))
        else $error("lower-priority source served first");

    a_global_rewrite: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_first && !take && !return_from_interrupt_i) |=>
            (gie_reg == $past(reg_wdata_i[GIE_BIT])))
        else $error("global enable write lost");

    // triggers are watched at the second synchroniser flop
    a_ovp_rise_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(sync_reg[ANA_OVP]) |=> flags_reg[SRC_OVP])
        else $error("over-voltage rise left flag clear");

    a_low_rise_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(sync_reg[ANA_LOW_SUP]) |=> flags_reg[SRC_LOW_SUP])
        else $error("low-supply rise left flag clear");

    // comparators flag both directions, a crossing either way is news
    a_cmp1_change_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $changed(sync_reg[ANA_CMP1]) |=> flags_reg[SRC_CMP1])
        else $error("comparator one change left flag clear");

    a_cmp2_change_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $changed(sync_reg[ANA_CMP2]) |=> flags_reg[SRC_CMP2])
        else $error("comparator two change left flag clear");

    a_cmp3_change_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $changed(sync_reg[ANA_CMP3]) |=> flags_reg[SRC_CMP3])
        else $error("comparator three change left flag clear");

    a_conv_done_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        conversion_done_i |=> flags_reg[SRC_CONV])
        else $error("conversion end left flag clear");

    a_mem_done_flag: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mem_write_done_i |=> flags_reg[SRC_MEM_WR])
        else $error("memory write end left flag clear");

    a_third_layout: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (reg_rd_i && (reg_addr_i == IRQ_CONTROL_THIRD_OFS)) |=>
            (reg_rdata_o == $past(third_view)))
        else $error("third control register read wrong");

    a_fourth_layout: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (reg_rd_i && (reg_addr_i == IRQ_CONTROL_FOURTH_OFS)) |=>
            (reg_rdata_o == $past(fourth_view)))
        else $error("fourth control register read wrong");

    a_third_write_lands: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_third && !take && (events == '0)) |=>
            (third_view == $past(reg_wdata_i)))
        else $error("write to third register lost");

    a_fourth_write_lands: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_fourth && !take && (events == '0)) |=>
            (fourth_view == $past(reg_wdata_i)))
        else $error("write to fourth register lost");

    a_wake_needs_rise: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wake_o |-> ((flags_reg & ~$past(flags_reg)) != '0))
        else $error("wake without a rising flag");

    a_pop_needs_ret: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !(return_from_interrupt_i || ret_i) |=> !core_reg.pop)
        else $error("pop without a return");

    a_core_busy_hold: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !core_ready_i |=> !core_reg.call)
        else $error("call forced while core not ready");
endmodule

//--- rtl/irq_pkg.sv
package irq_pkg;

    // sources, in default priority order (lowest index served first)
    localparam int NUM_SRC     = 15;
    localparam int SRC_IDX_W   = 4;
    localparam int PC_WIDTH    = 12;
    localparam int NUM_ANALOG  = 5;

    localparam int SRC_OVP     = 0;
    localparam int SRC_CMP1    = 1;
    localparam int SRC_PPG_INT = 2;
    localparam int SRC_TIMER0  = 3;
    localparam int SRC_CONV    = 4;
    localparam int SRC_CMP2    = 5;
    localparam int SRC_CMP3    = 6;
    localparam int SRC_LOW_SUP = 7;
    localparam int SRC_TIMER1  = 8;
    localparam int SRC_TIMER2  = 9;
    localparam int SRC_MEM_WR  = 10;
    localparam int SRC_P_TIMER = 11;
    localparam int SRC_P_CMP   = 12;
    localparam int SRC_P_RETRG = 13;
    localparam int SRC_SERIAL  = 14;

    // analog level lines, all asynchronous to ref_clk_i
    localparam int ANA_OVP     = 0;
    localparam int ANA_LOW_SUP = 1;
    localparam int ANA_CMP1    = 2;
    localparam int ANA_CMP2    = 3;
    localparam int ANA_CMP3    = 4;

    // register offsets on the plain register port
    localparam logic [1:0] IRQ_CONTROL_FIRST_OFS  = 2'h0;
    localparam logic [1:0] IRQ_CONTROL_SECOND_OFS = 2'h1;
    localparam logic [1:0] IRQ_CONTROL_THIRD_OFS  = 2'h2;
    localparam logic [1:0] IRQ_CONTROL_FOURTH_OFS = 2'h3;

    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
    localparam int         GIE_BIT           = 0;

    // vector table: entry n sits at base + n * step
    localparam int VECTOR_BASE = 'h004;
    localparam int VECTOR_STEP = 'h004;

    typedef struct packed {
        logic                call;
        logic                pop;
        logic [PC_WIDTH-1:0] vector;
        logic [PC_WIDTH-1:0] push_pc;
    } core_req_type;

endpackage

//--- verification/core_model.sv
`timescale 1ns/1ps
module core_model
    import irq_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          resetn_i,
    // controller side
    input  wire irq_pkg::core_req_type         core_i,
    input  wire logic                          slow_i,
    output logic      [irq_pkg::PC_WIDTH-1:0]  pc_o,
    output logic                               ready_o,
    output logic                               full_o
);
    import irq_pkg::*;
    logic [PC_WIDTH-1:0] stack_reg [DEPTH];
    int                  depth_reg;

    assign full_o = (depth_reg == DEPTH);

    // slow mode accepts a forced call only every other cycle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            depth_reg <= 0;
            pc_o      <= '0;
            ready_o   <= 1'b0;
        end else begin
            ready_o <= slow_i ? !ready_o : 1'b1;
            if (core_i.call && !full_o) begin
                stack_reg[depth_reg] <= core_i.push_pc;
                depth_reg            <= depth_reg + 1;
                pc_o                 <= core_i.vector;
            end else if (core_i.pop && depth_reg > 0) begin
                depth_reg <= depth_reg - 1;
                pc_o      <= stack_reg[depth_reg-1];
            end else begin
                pc_o <= pc_o + 1'b1;
            end
        end
    end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import irq_pkg::*;
    logic                ref_clk = 1'b0;
    logic                resetn  = 1'b0;
    logic [1:0]          addr    = 2'h0;
    logic [7:0]          wdata   = 8'h00;
    logic                wr      = 1'b0;
    logic                rd      = 1'b0;
    logic                return_from_interrupt    = 1'b0;
    logic                ret     = 1'b0;
    logic                slow    = 1'b0;
    logic [2:0]          tovf    = 3'h0;
    logic                conv    = 1'b0;
    logic                mem     = 1'b0;
    logic [3:0]          pev     = 4'h0;
    logic                ser     = 1'b0;
    logic [4:0]          ana     = 5'h00;
    logic [7:0]          rdata;
    logic [PC_WIDTH-1:0] pc;
    logic                ready;
    logic                full;
    logic                wake;
    core_req_type        core;
    logic [PC_WIDTH-1:0] last_pc, last_vec;
    logic [PC_WIDTH-1:0] saved [4];
    int                  sp = 0;
    int                  call_cnt = 0;
    int                  wake_cnt = 0;
    int                  error_cnt = 0;
    int                  checks_done = 0;
    int                  w0;

    always #5 ref_clk = ~ref_clk;

    vectored_interrupt_controller vectored_interrupt_controller_i (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pc_i(pc), .core_ready_i(ready),
        .stack_full_i(full), .return_from_interrupt_i(return_from_interrupt), .ret_i(ret), .core_o(core), .wake_o(wake),
        .timer_ovf_i(tovf), .conversion_done_i(conv), .mem_write_done_i(mem),
        .pulse_events_i(pev), .serial_bus_event_i(ser), .analog_level_i(ana));

    core_model core_model_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .core_i(core),
        .slow_i(slow), .pc_o(pc), .ready_o(ready), .full_o(full));

    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd <= 1'b1; addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk("reg_rdata", {4'h0, exp}, {4'h0, rdata});
    endtask

    task automatic clr_all();
        for (int a = 0; a < 4; a++) wreg(a[1:0], 8'h00);
    endtask

    // every event line pulses once; analog levels move to lvl
    task automatic fire(input logic [4:0] lvl);
        @(posedge ref_clk);
        tovf <= 3'h7; conv <= 1'b1; mem <= 1'b1; pev <= 4'hf; ser <= 1'b1; ana <= lvl;
        @(posedge ref_clk);
        tovf <= 3'h0; conv <= 1'b0; mem <= 1'b0; pev <= 4'h0; ser <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic wait_call(input int src);
        int n;
        n = call_cnt;
        for (int k = 0; k < 40 && call_cnt == n; k++) @(negedge ref_clk);
        chk("call_count", 12'(n + 1), 12'(call_cnt));
        chk("vector", 12'(VECTOR_BASE + VECTOR_STEP * src), last_vec);
    endtask

    task automatic no_call();
        int n;
        n = call_cnt;
        repeat (10) @(negedge ref_clk);
        chk("call_count", 12'(n), 12'(call_cnt));
    endtask

    // pc must come back to the address saved by the last call
    task automatic leave(input bit intr);
        @(posedge ref_clk);
        if (intr) return_from_interrupt <= 1'b1; else ret <= 1'b1;
        @(posedge ref_clk);
        return_from_interrupt <= 1'b0;
        ret  <= 1'b0;
        @(posedge ref_clk);
        #1 chk("resume_pc", saved[sp], pc);
    endtask

    always @(posedge ref_clk) begin
        last_pc <= pc;
        if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
        if (core.pop === 1'b1 && sp > 0) sp <= sp - 1;
        if (core.call === 1'b1) begin
            call_cnt  <= call_cnt + 1;
            last_vec  <= core.vector;
            saved[sp] <= core.push_pc;
            sp        <= sp + 1;
            chk("push_pc", last_pc, core.push_pc);
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        rreg(2'h2, 8'h00);
        rreg(2'h3, 8'h00);
        wreg(2'h3, 8'hff);
        rreg(2'h3, 8'hff);
        wreg(2'h2, 8'ha5);
        rreg(2'h2, 8'ha5);
        clr_all();
        // all enables off: flags still latch and wake fires
        w0 = wake_cnt;
        fire(5'h1f);
        rreg(2'h0, 8'h70);
        rreg(2'h1, 8'hf0);
        rreg(2'h2, 8'hf0);
        rreg(2'h3, 8'hf0);
        chk("wake_seen", 12'h1, {11'h0, wake_cnt > w0});
        chk("call_count", 12'h0, 12'(call_cnt));
        // flags already set before the events: no fresh wake
        wreg(2'h0, 8'h70);
        w0 = wake_cnt;
        fire(5'h1f);
        chk("wake_blocked", 12'(w0), 12'(wake_cnt));
        clr_all();
        fire(5'h00);
        rreg(2'h0, 8'h60);
        rreg(2'h1, 8'hf0);
        rreg(2'h2, 8'he0);
        clr_all();
        wreg(2'h2, 8'h20);
        wreg(2'h0, 8'h01);
        no_call();
        wreg(2'h0, 8'h00);
        wreg(2'h2, 8'h22);
        no_call();
        wreg(2'h0, 8'h01);
        wait_call(SRC_TIMER1);
        rreg(2'h0, 8'h00);
        rreg(2'h2, 8'h02);
        fire(5'h00);
        rreg(2'h1, 8'h30);
        rreg(2'h2, 8'he2);
        leave(1'b0);
        rreg(2'h0, 8'h40);
        clr_all();
        // every source pending at once, core answering slowly
        slow <= 1'b1;
        wreg(2'h1, 8'hff);
        wreg(2'h2, 8'hff);
        wreg(2'h3, 8'hff);
        wreg(2'h0, 8'h7f);
        for (int i = 0; i < NUM_SRC; i++) begin
            wait_call(i);
            leave(1'b1);
        end
        rreg(2'h0, 8'h0f);
        clr_all();
        slow <= 1'b0;
        // nesting until the two-deep stack is full
        wreg(2'h2, 8'h0f);
        wreg(2'h0, 8'h01);
        wreg(2'h2, 8'h1f);
        wait_call(SRC_LOW_SUP);
        wreg(2'h2, 8'h2f);
        wreg(2'h0, 8'h01);
        wait_call(SRC_TIMER1);
        wreg(2'h2, 8'h4f);
        wreg(2'h0, 8'h01);
        no_call();
        leave(1'b1);
        wait_call(SRC_TIMER2);
        leave(1'b1);
        leave(1'b1);
        rreg(2'h2, 8'h0f);
        print_verdict();
    end
endmodule
